// [common/hrs_pkg.sv]
package hrs_pkg;
	// Clock rate
	localparam int CLK_MHZ = 125;
	// Reset pulse the outside world must give (not checked by any logic here)
	localparam int RESET_MIN_US = 1;
	// Recovery after reset release, longest time
	localparam int RECOVER_MAX_US = 500;
	localparam int RECOVER_CYC = RECOVER_MAX_US * CLK_MHZ;
	// Configuration load limit, 99.5 ms held in tenths of a millisecond
	localparam int LOAD_MAX_MS_X10 = 995;
	localparam int LOAD_MAX_CYC = LOAD_MAX_MS_X10 * CLK_MHZ * 100;
	// Attach after load, longest time
	localparam int ATTACH_MAX_MS = 100;
	localparam int ATTACH_MAX_CYC = ATTACH_MAX_MS * CLK_MHZ * 1000;
	// Cycles spent applying the configuration before attach
	localparam int APPLY_CYC = 16;
	// Request completion limit
	localparam int REQ_MAX_MS = 5;
	localparam int REQ_MAX_CYC = REQ_MAX_MS * CLK_MHZ * 1000;
	// Timer width covers the longest load
	localparam int TMR_W = 24;
	localparam int NPORTS = 4;
	localparam int ADDR_W = 7;
	// Configuration select code for SMBus slave loading
	localparam logic [1:0] CFG_SEL_SMB = 2'h1;
	// APB register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	// Control register: downstream power mask in the low bits
	localparam logic [NPORTS-1:0] CTRL_RST = 4'hf;
	// Status register fields
	localparam int ST_TEST_B = 0;
	localparam int ST_SMB_B = 1;
	localparam int ST_ATT_B = 2;
	localparam int ST_CFG_B = 3;
	localparam int ST_SUSP_B = 4;
	localparam int ST_LOADTO_B = 5;
	localparam int ST_REQLATE_B = 6;
	localparam int ST_ADDR_LSB = 8;
	localparam int ST_STATE_LSB = 16;
	typedef enum logic [2:0] {
		ST_SAMPLE, ST_RECOVER, ST_EE_LOAD, ST_SMB_WAIT, ST_APPLY, ST_ATTACHED, ST_RUN, ST_TEST
	} hrs_state_t;
endpackage

// [common/hrs_tmr_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface hrs_tmr_if;
	import hrs_pkg::*;
	logic load;
	logic stop;
	logic [TMR_W-1:0] value;
	logic expired;
	modport ctl(output load, output stop, output value, input expired);
	modport tmr(input load, input stop, input value, output expired);
endinterface
`default_nettype wire

// [verilog/hrs_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module hrs_timer import hrs_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	hrs_tmr_if.tmr t
);
	logic [TMR_W-1:0] cnt_r;
	logic armed_r;

	// Load starts a count; expired holds until the next load or stop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
			armed_r <= 1'b0;
		end else if (t.load) begin
			cnt_r <= t.value;
			armed_r <= 1'b1;
		end else if (t.stop) begin
			armed_r <= 1'b0;
		end else if (armed_r && cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign t.expired = armed_r && (cnt_r == '0);
endmodule
`default_nettype wire

// [verilog/hrs_xnor_chain.sv]
`timescale 1ns/10ps
`default_nettype none
module hrs_xnor_chain #(
	parameter int W = 32
) (
	input wire logic [W-1:0] pins_i,
	output logic chain_o
);
	logic [W:0] link;

	// Each stage folds one pin in, so any single pin toggle flips the end
	assign link[0] = 1'b1;
	for (genvar i = 0; i < W; i++) begin : g_stage
		assign link[i+1] = ~(link[i] ^ pins_i[i]);
	end
	assign chain_o = link[W];
endmodule
`default_nettype wire

// [verilog/hrs_sequencer.sv]
// How it works
// RQ1 - Reset source holds the reset pin low at least one microsecond.
// RQ2 - EEPROM mode: recover within 500 us, then load config, at most 99.5 ms.
// RQ3 - EEPROM mode: attach upstream within 100 ms of load completion.
// RQ4 - SMBus mode: wait for external load; bus-powered limit 99.5 ms.
// RQ5 - SMBus mode, self-powered: wait for the load with no time limit.
// RQ6 - SMBus mode: apply config and attach within 100 ms of load end.
// RQ7 - Host waits at least 100 ms after attach before bus reset.
// RQ8 - After bus reset each host request completes within 5 ms.
// RQ9 - Upstream bus reset is never passed to downstream ports.
// RQ10 - Bus reset returns the device address to zero.
// RQ11 - Bus reset returns the device to unconfigured.
// RQ12 - Bus reset drops all four downstream port power enables.
// RQ13 - Bus reset clears all transaction translator buffers.
// RQ14 - Bus reset takes a suspended device back to active.
// RQ15 - Test select, config select bit 1 high, SMBus clock low at release: test mode.
// RQ16 - Test mode drives the XNOR chain result onto the chain output.
// RQ17 - The chain covers every tested signal pin given to it.
// RQ18 - Until loading ends, stay detached with port power off.
// RQ19 - Load sequence chosen from config select sampled at reset release.
`timescale 1ns/10ps
`default_nettype none
module hrs_sequencer import hrs_pkg::*; #(
	parameter int RECOVER_CYC_P = RECOVER_CYC,
	parameter int LOAD_MAX_CYC_P = LOAD_MAX_CYC,
	parameter int REQ_MAX_CYC_P = REQ_MAX_CYC,
	parameter int CHAIN_W = 32
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [1:0] cfg_sel_i,
	input wire logic test_select_pin_i,
	input wire logic smb_clk_i,
	input wire logic self_powered_i,
	input wire logic ee_load_done_i,
	input wire logic smb_load_done_i,
	input wire logic usb_bus_reset_i,
	input wire logic suspend_req_i,
	input wire logic set_addr_i,
	input wire logic [ADDR_W-1:0] addr_val_i,
	input wire logic set_config_i,
	input wire logic config_nonzero_i,
	input wire logic [NPORTS-1:0] port_power_on_i,
	input wire logic req_busy_i,
	input wire logic [CHAIN_W-1:0] chain_pins_i,
	output logic ee_load_start_o,
	output logic smb_slave_en_o,
	output logic upstream_attach_o,
	output logic [NPORTS-1:0] port_power_enable_o,
	output logic [ADDR_W-1:0] usb_addr_o,
	output logic configured_o,
	output logic suspended_o,
	output logic tt_clear_o,
	output logic ds_port_reset_o,
	output logic req_abort_o,
	output logic test_mode_o,
	output logic chain_result_output_o
);
	localparam int ATTACH_WIN = APPLY_CYC + 4;

	logic rst_meta_r, rst_sync_n_r;
	hrs_state_t state_r, state_nxt;
	logic smb_mode_r, test_mode_r, attach_r, configured_r, suspended_r;
	logic tt_clear_r, ds_rst_r, ee_start_r, smb_en_r, abort_r, chain_r;
	logic load_to_r, req_late_r, busy_d_r, pready_r, pslverr_r;
	logic [ADDR_W-1:0] addr_r;
	logic [NPORTS-1:0] pwr_r, pwr_mask_r;
	logic [31:0] prdata_r, stat_w;
	logic tmr_load, tmr_stop, load_timeout;
	logic [TMR_W-1:0] tmr_value;
	logic chain_w;
	hrs_tmr_if tm();

	// Reset release through two flip-flops
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	hrs_timer u_timer (
		.clk_i(core_clk_i),
		.rst_n_i(rst_sync_n_r),
		.t(tm.tmr)
	);

	hrs_xnor_chain #(.W(CHAIN_W)) u_chain (
		.pins_i(chain_pins_i),
		.chain_o(chain_w)
	);

	// Strap decode and event qualifiers
	wire test_strap = test_select_pin_i & cfg_sel_i[1] & ~smb_clk_i; // RQ15
	wire smb_strap = (cfg_sel_i == CFG_SEL_SMB); // RQ19
	wire linked = (state_r == ST_ATTACHED) || (state_r == ST_RUN);
	wire bus_rst = usb_bus_reset_i && linked;
	wire in_run = (state_r == ST_RUN);
	wire req_rise = in_run && req_busy_i && !busy_d_r;
	wire req_over = in_run && req_busy_i && tm.expired;
	wire ee_done = (state_r == ST_EE_LOAD) && ee_load_done_i;
	wire smb_done = (state_r == ST_SMB_WAIT) && smb_load_done_i;

	assign tm.load = tmr_load;
	assign tm.stop = tmr_stop;
	assign tm.value = tmr_value;

	// Power-up sequence and request watchdog
	always_comb begin
		state_nxt = state_r;
		tmr_load = 1'b0;
		tmr_stop = 1'b0;
		tmr_value = '0;
		load_timeout = 1'b0;
		case (state_r)
			ST_SAMPLE: begin
				tmr_load = 1'b1;
				tmr_value = TMR_W'(RECOVER_CYC_P); // RQ2
				state_nxt = test_strap ? ST_TEST : ST_RECOVER; // RQ15
			end
			ST_RECOVER: begin
				if (tm.expired) begin
					tmr_load = 1'b1;
					tmr_value = TMR_W'(LOAD_MAX_CYC_P);
					state_nxt = smb_mode_r ? ST_SMB_WAIT : ST_EE_LOAD; // RQ19
				end
			end
			ST_EE_LOAD: begin
				if (ee_load_done_i || tm.expired) begin // RQ2
					tmr_load = 1'b1;
					tmr_value = TMR_W'(APPLY_CYC);
					load_timeout = !ee_load_done_i;
					state_nxt = ST_APPLY;
				end
			end
			ST_SMB_WAIT: begin
				if (smb_load_done_i || (tm.expired && !self_powered_i)) begin // RQ4 RQ5
					tmr_load = 1'b1;
					tmr_value = TMR_W'(APPLY_CYC);
					load_timeout = !smb_load_done_i;
					state_nxt = ST_APPLY;
				end
			end
			ST_APPLY: begin
				if (tm.expired) begin // RQ3 RQ6
					tmr_stop = 1'b1;
					state_nxt = ST_ATTACHED;
				end
			end
			ST_ATTACHED: begin
				if (usb_bus_reset_i) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (req_rise) begin
					tmr_load = 1'b1;
					tmr_value = TMR_W'(REQ_MAX_CYC_P); // RQ8
				end else if (!req_busy_i || tm.expired) begin
					tmr_stop = 1'b1;
				end
			end
			ST_TEST: begin
				state_nxt = ST_TEST;
			end
			default: begin
				state_nxt = ST_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			state_r <= ST_SAMPLE;
			busy_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_d_r <= req_busy_i;
		end
	end

	// Straps caught in the first cycle after release
	always_ff @(posedge core_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			smb_mode_r <= 1'b0;
		end else if (state_r == ST_SAMPLE) begin
			smb_mode_r <= smb_strap; // RQ19
		end
	end

	// Sequence outputs; detached and unpowered until loading is over
	always_ff @(posedge core_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			attach_r <= 1'b0;
			ds_rst_r <= 1'b1;
			ee_start_r <= 1'b0;
			smb_en_r <= 1'b0;
			test_mode_r <= 1'b0;
			chain_r <= 1'b0;
		end else begin
			attach_r <= linked; // RQ18
			ds_rst_r <= !linked && (state_r != ST_TEST); // RQ9
			ee_start_r <= (state_r == ST_RECOVER) && (state_nxt == ST_EE_LOAD); // RQ2
			smb_en_r <= (state_nxt == ST_SMB_WAIT); // RQ4
			test_mode_r <= (state_nxt == ST_TEST);
			chain_r <= (state_r == ST_TEST) && chain_w; // RQ16 RQ17
		end
	end

	// Device state cleared by upstream bus reset, plus the request abort pulse
	always_ff @(posedge core_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			addr_r <= '0;
			configured_r <= 1'b0;
			suspended_r <= 1'b0;
			tt_clear_r <= 1'b0;
			abort_r <= 1'b0;
		end else begin
			addr_r <= bus_rst ? '0 : ((set_addr_i && in_run) ? addr_val_i : addr_r); // RQ10
			configured_r <= bus_rst ? 1'b0 : ((set_config_i && in_run) ? config_nonzero_i : configured_r); // RQ11
			suspended_r <= linked && !bus_rst && suspend_req_i; // RQ14
			tt_clear_r <= bus_rst; // RQ13
			abort_r <= req_over; // RQ8
		end
	end

	// Per-port power enable, gated by mask and configuration
	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		always_ff @(posedge core_clk_i or negedge rst_sync_n_r) begin
			if (!rst_sync_n_r) begin
				pwr_r[p] <= 1'b0;
			end else if (bus_rst || !configured_r || !pwr_mask_r[p]) begin
				pwr_r[p] <= 1'b0; // RQ12 RQ18
			end else if (port_power_on_i[p]) begin
				pwr_r[p] <= 1'b1;
			end
		end
	end

	// APB decode; zero-wait answer one cycle after setup
	wire apb_setup = psel_i && !penable_i;
	wire apb_acc = psel_i && penable_i && pready_r;
	wire hit_ctrl = (paddr_i == OFF_CTRL);
	wire hit_stat = (paddr_i == OFF_STATUS);
	wire wr_ctrl = apb_acc && pwrite_i && hit_ctrl;
	wire wr_stat = apb_acc && pwrite_i && hit_stat;
	wire clr_loadto = wr_stat && pwdata_i[ST_LOADTO_B];
	wire clr_reqlate = wr_stat && pwdata_i[ST_REQLATE_B];
	wire [31:0] rd_val = hit_ctrl ? {28'h0000000, pwr_mask_r} : (hit_stat ? stat_w : 32'h00000000);

	always_comb begin
		stat_w = '0;
		stat_w[ST_TEST_B] = test_mode_r;
		stat_w[ST_SMB_B] = smb_mode_r;
		stat_w[ST_ATT_B] = attach_r;
		stat_w[ST_CFG_B] = configured_r;
		stat_w[ST_SUSP_B] = suspended_r;
		stat_w[ST_LOADTO_B] = load_to_r;
		stat_w[ST_REQLATE_B] = req_late_r;
		stat_w[ST_ADDR_LSB +: ADDR_W] = addr_r;
		stat_w[ST_STATE_LSB +: 3] = state_r;
	end

	always_ff @(posedge core_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
			pwr_mask_r <= CTRL_RST;
		end else begin
			pready_r <= apb_setup;
			pslverr_r <= apb_setup && !(hit_ctrl || hit_stat);
			prdata_r <= apb_setup ? rd_val : 32'h00000000;
			pwr_mask_r <= wr_ctrl ? pwdata_i[NPORTS-1:0] : pwr_mask_r;
		end
	end

	// Sticky flags: a new event wins over a write-one clear
	always_ff @(posedge core_clk_i or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			load_to_r <= 1'b0;
			req_late_r <= 1'b0;
		end else begin
			load_to_r <= load_timeout || (load_to_r && !clr_loadto);
			req_late_r <= req_over || (req_late_r && !clr_reqlate); // RQ8
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign ee_load_start_o = ee_start_r;
	assign smb_slave_en_o = smb_en_r;
	assign upstream_attach_o = attach_r;
	assign port_power_enable_o = pwr_r;
	assign usb_addr_o = addr_r;
	assign configured_o = configured_r;
	assign suspended_o = suspended_r;
	assign tt_clear_o = tt_clear_r;
	assign ds_port_reset_o = ds_rst_r;
	assign req_abort_o = abort_r;
	assign test_mode_o = test_mode_r;
	assign chain_result_output_o = chain_r;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_sync_n_r);

	ee_start_a: assert property ((state_r == ST_RECOVER) && tm.expired && !smb_mode_r |=> ee_start_r ##1 !ee_start_r) // RQ2
		else $error("eeprom load not started after recovery");
	ee_limit_a: assert property ((state_r == ST_EE_LOAD) && tm.expired && !ee_load_done_i |=> (state_r == ST_APPLY) && load_to_r) // RQ2
		else $error("eeprom load overran its limit");
	smb_bus_a: assert property ((state_r == ST_SMB_WAIT) && tm.expired && !self_powered_i && !smb_load_done_i |=> state_r == ST_APPLY) // RQ4
		else $error("bus-powered smbus load overran its limit");
	smb_self_a: assert property ((state_r == ST_SMB_WAIT) && self_powered_i && !smb_load_done_i |=> state_r == ST_SMB_WAIT) // RQ5
		else $error("self-powered smbus wait ended early");
	attach_time_a: assert property ((ee_done || smb_done) |-> ##[1:ATTACH_WIN] attach_r) // RQ3 RQ6
		else $error("attach late after configuration load");
	req_abort_a: assert property (req_over |=> abort_r && req_late_r) // RQ8
		else $error("overlong request not aborted");
	bus_reset_a: assert property (bus_rst |=> (addr_r == '0) && !configured_r && (pwr_r == '0) && tt_clear_r && !suspended_r) // RQ10 RQ11 RQ12 RQ13 RQ14
		else $error("bus reset left device state");
	no_fwd_a: assert property (bus_rst |=> !ds_rst_r [*2]) // RQ9
		else $error("bus reset reached downstream ports");
	detach_a: assert property (!linked |=> !attach_r && (pwr_r == '0)) // RQ18
		else $error("attached or powered before load end");
	mode_sel_a: assert property ((state_r == ST_SAMPLE) && !test_strap |=> (smb_mode_r == $past(smb_strap)) && (state_r == ST_RECOVER)) // RQ19
		else $error("load mode not taken from straps");
	test_entry_a: assert property ((state_r == ST_SAMPLE) && test_strap |=> (state_r == ST_TEST) && test_mode_r) // RQ15
		else $error("test mode not entered");
	chain_flip_a: assert property ((state_r == ST_TEST) && $past(state_r == ST_TEST) && ($countones(chain_pins_i ^ $past(chain_pins_i)) == 1) |=> chain_r != $past(chain_r)) // RQ16 RQ17
		else $error("chain output did not toggle");

	ee_run_c: cover property (!smb_mode_r && (state_r == ST_ATTACHED) ##1 (state_r == ST_RUN));
	smb_run_c: cover property (smb_mode_r && (state_r == ST_ATTACHED) ##1 (state_r == ST_RUN));
	test_c: cover property (test_mode_r && chain_r);
	abort_c: cover property (abort_r);
endmodule
`default_nettype wire

// [testbench/hrs_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
module hrs_far_model #(
	parameter int LOAD_DLY = 10,
	parameter int HOST_WAIT = 40
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ee_start_i,
	input wire logic smb_en_i,
	input wire logic attach_i,
	input wire logic hold_i,
	input wire logic kick_i,
	output logic ee_done_o,
	output logic smb_done_o,
	output logic bus_reset_o
);
	int ld_r;
	int at_r;
	logic ee_busy_r;
	logic run;
	// A load engine runs unless stalled: the reader while busy, the host while enabled
	assign run = (ee_busy_r || smb_en_i) && !hold_i;
	// Reader and host finish after a delay; host waits before bus reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ld_r <= 0;
			at_r <= 0;
			ee_busy_r <= 1'b0;
			ee_done_o <= 1'b0;
			smb_done_o <= 1'b0;
			bus_reset_o <= 1'b0;
		end else begin
			ee_busy_r <= ee_start_i || (ee_busy_r && !ee_done_o);
			ld_r <= (run && ld_r < LOAD_DLY) ? ld_r + 1 : 0;
			ee_done_o <= ee_busy_r && ld_r == LOAD_DLY;
			smb_done_o <= smb_en_i && !hold_i && ld_r == LOAD_DLY;
			at_r <= (attach_i && at_r <= HOST_WAIT) ? at_r + 1 : at_r;
			bus_reset_o <= (at_r == HOST_WAIT) || kick_i;
		end
	end
endmodule
`default_nettype wire

// [testbench/hrs_sequencer_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITC(c,n) for (int k = 0; k < (n) && !(c); k++) @(posedge clk);
module hrs_sequencer_tb import hrs_pkg::*;;
	localparam int RC = 20;
	localparam int LM = 50;
	localparam int RM = 30;
	localparam int HW = 40;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, pins = 32'h0, prdata;
	logic [1:0] cfg_sel = 2'h0;
	logic tsel = 0, sclk = 1, self_pw = 0, susp_req = 0, set_addr = 0, set_cfg = 0, cfg_nz = 0;
	logic req_busy = 0, hold = 0, kick = 0;
	logic [6:0] addr_val = 7'h0, addr;
	logic [3:0] pp_on = 4'h0, ppe;
	logic pready, pslverr, ee_start, smb_en, attach, cfgd, susp, ttc, dsr, abort, tmode, chain;
	logic ee_done, smb_done, bus_rst;
	hrs_sequencer #(.RECOVER_CYC_P(RC), .LOAD_MAX_CYC_P(LM), .REQ_MAX_CYC_P(RM), .CHAIN_W(32)) uut (
		.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.cfg_sel_i(cfg_sel), .test_select_pin_i(tsel), .smb_clk_i(sclk), .self_powered_i(self_pw),
		.ee_load_done_i(ee_done), .smb_load_done_i(smb_done), .usb_bus_reset_i(bus_rst),
		.suspend_req_i(susp_req), .set_addr_i(set_addr), .addr_val_i(addr_val), .set_config_i(set_cfg),
		.config_nonzero_i(cfg_nz), .port_power_on_i(pp_on), .req_busy_i(req_busy), .chain_pins_i(pins),
		.ee_load_start_o(ee_start), .smb_slave_en_o(smb_en), .upstream_attach_o(attach),
		.port_power_enable_o(ppe), .usb_addr_o(addr), .configured_o(cfgd), .suspended_o(susp),
		.tt_clear_o(ttc), .ds_port_reset_o(dsr), .req_abort_o(abort), .test_mode_o(tmode),
		.chain_result_output_o(chain));
	hrs_far_model #(.LOAD_DLY(10), .HOST_WAIT(HW)) far (.clk_i(clk), .rst_n_i(rst_n),
		.ee_start_i(ee_start), .smb_en_i(smb_en), .attach_i(attach), .hold_i(hold), .kick_i(kick),
		.ee_done_o(ee_done), .smb_done_o(smb_done), .bus_reset_o(bus_rst));
	// Clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end
	// Final report
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench's own cycle ceiling ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Hardware reset with straps held across the release
	task automatic do_reset(input logic [1:0] cs, input logic ts, input logic sc, input logic sp);
		rst_n <= 1'b0;
		cfg_sel <= cs;
		tsel <= ts;
		sclk <= sc;
		self_pw <= sp;
		req_busy <= 1'b0;
		susp_req <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// EEPROM load, attach, register access
	task automatic t_eeprom();
		logic [31:0] rd;
		logic er;
		int n;
		do_reset(2'h0, 1'b1, 1'b1, 1'b0);
		n = 0;
		while (ee_start !== 1'b1 && n < RC + 20) begin
			@(posedge clk);
			n++;
		end
		`CHK(n <= RC + 8, 1'b1)
		`CHK({smb_en, tmode}, 2'b00)
		`CHK({attach, ppe}, 5'h0)
		`WAITC(attach === 1'b1, 40)
		`CHK(attach, 1'b1)
		apb(1'b0, OFF_STATUS, 32'h0, rd, er);
		`CHK({er, rd[2:0]}, 4'b0100)
		apb(1'b0, 8'h40, 32'h0, rd, er);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b0, OFF_CTRL, 32'h0, rd, er);
		`CHK(rd[3:0], 4'hf)
		apb(1'b1, OFF_CTRL, 32'h5, rd, er);
	endtask
	// Host bus reset clears address, config, power, buffers, suspend
	task automatic t_busreset();
		`WAITC(bus_rst === 1'b1, HW + 10)
		@(negedge clk);
		`CHK({ttc, dsr}, 2'b10)
		@(posedge clk);
		set_addr <= 1'b1;
		addr_val <= 7'h2a;
		set_cfg <= 1'b1;
		cfg_nz <= 1'b1;
		susp_req <= 1'b1;
		@(posedge clk);
		set_addr <= 1'b0;
		set_cfg <= 1'b0;
		pp_on <= 4'hf;
		@(posedge clk);
		pp_on <= 4'h0;
		repeat (3) @(posedge clk);
		`CHK({addr, cfgd, susp, ppe}, {7'h2a, 2'b11, 4'h5})
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		`WAITC(bus_rst === 1'b1, 4)
		@(negedge clk);
		`CHK(addr, 7'h0)
		`CHK(cfgd, 1'b0)
		`CHK(ppe, 4'h0)
		`CHK(ttc, 1'b1)
		`CHK(susp, 1'b0)
		`CHK({dsr, attach}, 2'b01)
	endtask
	// Request stuck busy is cut off at the limit
	task automatic t_watchdog();
		logic [31:0] rd;
		logic er;
		int n;
		@(posedge clk);
		req_busy <= 1'b1;
		n = 0;
		while (abort !== 1'b1 && n < RM + 20) begin
			@(posedge clk);
			n++;
		end
		`CHK(n >= RM && n <= RM + 4, 1'b1)
		req_busy <= 1'b0;
		apb(1'b0, OFF_STATUS, 32'h0, rd, er);
		`CHK(rd[6], 1'b1)
		apb(1'b1, OFF_STATUS, 32'h40, rd, er);
		apb(1'b0, OFF_STATUS, 32'h0, rd, er);
		`CHK(rd[6], 1'b0)
	endtask
	// SMBus host load with the host stalling past the limit
	task automatic t_smb(input logic sp);
		logic [31:0] rd;
		logic er;
		hold <= 1'b1;
		do_reset(CFG_SEL_SMB, 1'b0, 1'b1, sp);
		`WAITC(smb_en === 1'b1, RC + 10)
		`CHK({smb_en, ee_start}, 2'b10)
		repeat (LM + 6) @(posedge clk);
		`CHK({smb_en, attach, ppe}, {sp, 5'h0})
		hold <= 1'b0;
		`WAITC(attach === 1'b1, 60)
		`CHK(attach, 1'b1)
		apb(1'b0, OFF_STATUS, 32'h0, rd, er);
		`CHK(rd[5:1], {~sp, 4'b0011})
	endtask
	// EEPROM reader stalled past the load limit; device attaches with defaults
	task automatic t_ee_stall();
		logic [31:0] rd;
		logic er;
		hold <= 1'b1;
		do_reset(2'h0, 1'b0, 1'b1, 1'b0);
		`WAITC(attach === 1'b1, RC + LM + 40)
		`CHK(attach, 1'b1)
		apb(1'b0, OFF_STATUS, 32'h0, rd, er);
		`CHK({rd[5], rd[2:1]}, 3'b110)
		hold <= 1'b0;
	endtask
	// Continuity chain follows every tested pin
	task automatic t_xnor();
		pins <= 32'h0;
		do_reset(2'h2, 1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		`CHK({tmode, chain, attach}, 3'b110)
		for (int i = 0; i < 32; i++) begin
			pins[i] <= ~pins[i];
			repeat (3) @(posedge clk);
			`CHK(chain, ~^pins)
		end
		`CHK(chain, 1'b1)
	endtask
	// Main sequence
	initial begin
		t_eeprom();
		t_busreset();
		t_watchdog();
		t_smb(1'b1);
		t_smb(1'b0);
		t_ee_stall();
		t_xnor();
		end_of_test();
	end
endmodule
`default_nettype wire
